// File: inc/pa_pkg.sv
package pa_pkg;
   // ***************************************************
   // Register byte offsets
   // ***************************************************
   localparam logic [7:0] A_MODE  = 8'h00;
   localparam logic [7:0] A_WTMR  = 8'h04;
   localparam logic [7:0] A_CFG   = 8'h08;
   localparam logic [7:0] A_PTIME = 8'h0C;
   localparam logic [7:0] A_DIV   = 8'h10;
   localparam logic [7:0] A_STAT  = 8'h20;
   localparam logic [7:0] A_EVT   = 8'h24;
   localparam logic [7:0] A_MASK  = 8'h28;
   localparam logic [7:0] A_SIGN  = 8'h2C;
   localparam logic [7:0] A_PWR   = 8'h30;
   localparam logic [7:0] A_PN    = 8'h54;
   localparam logic [7:0] A_END   = 8'h64;
   // ***************************************************
   // Sizes, field positions, reset values
   // ***************************************************
   localparam int NOUT = 4;
   localparam int NPH  = 3;
   localparam int NPWR = 9;
   localparam int ST_W = 15;
   localparam int MODE_WM  = 4;
   localparam int MODE_SS  = 8;
   localparam int ST_RDY   = 0;
   localparam int ST_REV   = 4;
   localparam int ST_RAP   = 8;
   localparam int ST_RRP   = 11;
   localparam int ST_PRDY  = 14;
   localparam logic [15:0] DIV_RST   = 16'hFFFF;
   localparam logic [15:0] DIV_MIN   = 16'h0002;
   localparam logic [18:0] WTMR_RST  = 19'h50000;
   localparam logic [12:0] PTIME_RST = 13'h0F9F;
   // ***************************************************
   // Timing
   // ***************************************************
   localparam int CLK_NS   = 50;
   localparam int FIX_W_NS = 80_000_000;
   localparam int FIX_CYC  = FIX_W_NS / CLK_NS;
   localparam int TMR_MULT = 6;
   // ***************************************************
   // Types
   // ***************************************************
   typedef struct packed {
      logic [31:0] act;
      logic [31:0] rct;
      logic [31:0] frct;
   } pa_pwr_t;
   typedef enum {PS_IDLE, PS_LOW} pa_pst_t;
endpackage

// File: verilog/pa_top.sv
// Contract
// - Mode 0, slow rate: 80 ms low pulse
// - Mode 0, fast: 50% or odd-divider duty
// - Mode 1, slow rate: width is timer times six clocks
// - Per-output sign of last pulse energy
// - Sign change sets reversal flags, interrupt
// - Clear bit zeroes accumulator, self-clears
// - Disabled output held high, no pulses
// - Disabled: no ready bit, reversal still works
// - Accumulate interval+1 samples, latch, ready
// - Interval setting is 13 bits wide
// - User register is accumulator bits 44:13
// - Per-phase active/reactive reversal flags
// - Select total or fundamental for reactive sign
// - Signs update with user power registers
// - Split positive and negative magnitudes
// - Sum phases, restart each interval
// - One output per divider internal pulses
// - No-load hold in mode 1, finish in 0
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
module pa_top
   import pa_pkg::*;
#(
   parameter int unsigned FIX_W_CYC = FIX_CYC
)(
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // Power samples and converter pulses
   input  wire logic              smp_stb,
   input  wire pa_pwr_t           smp [NPH],
   input  wire logic [NOUT-1:0]   dfc_pulse,
   input  wire logic [NOUT-1:0]   dfc_neg,
   input  wire logic              no_load,
   // Outputs
   output logic                   dfc_clr,
   output logic [NOUT-1:0]        cf_n,
   output logic                   int_line_zero_n
);

   // ***************************************************
   // State
   // ***************************************************
   logic [8:0]         mode_ff, nxt_mode;
   logic [18:0]        wtmr_ff, nxt_wtmr;
   logic [12:0]        ptime_ff, nxt_ptime;
   logic [15:0]        div_ff [NOUT];
   logic [15:0]        nxt_div [NOUT];
   logic [ST_W-1:0]    stat_ff, nxt_stat;
   logic [ST_W-1:0]    evt_ff, nxt_evt;
   logic [ST_W-1:0]    mask_ff, nxt_mask;
   logic               clr_ff, nxt_clr;
   logic [7:0]         addr_ff, nxt_addr;
   logic               wr_ff, nxt_wr;
   logic [31:0]        rd_ff, nxt_rd;
   pa_pst_t            st_ff [NOUT];
   pa_pst_t            nxt_st [NOUT];
   logic [15:0]        cnt_ff [NOUT];
   logic [15:0]        nxt_cnt [NOUT];
   logic [15:0]        half_ff [NOUT];
   logic [15:0]        nxt_half [NOUT];
   logic signed [16:0] net_ff [NOUT];
   logic signed [16:0] nxt_net [NOUT];
   logic [20:0]        wcnt_ff [NOUT];
   logic [20:0]        nxt_wcnt [NOUT];
   logic [NOUT-1:0]    sgn_ff, nxt_sgn;
   logic [NOUT-1:0]    seen_ff, nxt_seen;
   logic signed [44:0] acc_ff [NPWR];
   logic signed [44:0] nxt_acc [NPWR];
   logic [31:0]        usr_ff [NPWR];
   logic [31:0]        nxt_usr [NPWR];
   logic signed [44:0] pn_ff [4];
   logic signed [44:0] nxt_pn [4];
   logic [31:0]        pnu_ff [4];
   logic [31:0]        nxt_pnu [4];
   logic [12:0]        scnt_ff, nxt_scnt;
   logic [2:0]         asgn_ff, nxt_asgn;
   logic [2:0]         rsgn_ff, nxt_rsgn;
   logic               pw_rdy;
   logic [2:0]         rap, rrp;

   // Pick one power type from a sample
   function automatic logic [31:0] pick(pa_pwr_t w, int t);
      pick = (t == 0) ? w.act : ((t == 1) ? w.rct : w.frct);
   endfunction

   // Sign-extend a sample to accumulator width
   function automatic logic signed [44:0] sx(logic [31:0] x);
      sx = {{13{x[31]}}, x};
   endfunction

   // ***************************************************
   // Bus answer and outputs
   // ***************************************************
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_ff;
   assign dfc_clr = clr_ff;
   assign int_line_zero_n = ~|(stat_ff & mask_ff);
   always_comb begin
      for (int i = 0; i < NOUT; i++) begin
         cf_n[i] = (st_ff[i] != PS_LOW);
      end
   end

   // ***************************************************
   // Registers, pulse outputs, status
   // ***************************************************
   always_comb begin
      logic               take;
      logic               inc;
      logic               emit;
      logic               hold;
      logic               wend;
      logic signed [16:0] net_n;
      logic [20:0]        lim;
      logic [15:0]        hlim;
      logic [7:0]         ra;
      logic [3:0]         idx;
      logic [ST_W-1:0]    setv;
      take = hsel && hready && htrans[1];
      inc = 1'b0;
      emit = 1'b0;
      hold = 1'b0;
      wend = 1'b0;
      net_n = '0;
      lim = '0;
      hlim = '0;
      ra = haddr[7:0];
      idx = '0;
      setv = '0;
      nxt_mode = mode_ff;
      nxt_wtmr = wtmr_ff;
      nxt_ptime = ptime_ff;
      nxt_div = div_ff;
      nxt_mask = mask_ff;
      nxt_clr = 1'b0;
      nxt_wr = take && hwrite;
      nxt_addr = take ? ra : addr_ff;
      nxt_rd = rd_ff;
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_half = half_ff;
      nxt_net = net_ff;
      nxt_wcnt = wcnt_ff;
      nxt_sgn = sgn_ff;
      nxt_seen = seen_ff;
      // Register writes in the data phase
      if (wr_ff) begin
         case (addr_ff)
            A_MODE:  nxt_mode = hwdata[8:0];
            A_WTMR:  nxt_wtmr = hwdata[18:0];
            A_CFG:   nxt_clr = hwdata[0];
            A_PTIME: nxt_ptime = hwdata[12:0];
            A_MASK:  nxt_mask = hwdata[ST_W-1:0];
            default: begin
               if (addr_ff >= A_DIV && addr_ff < A_STAT) begin
                  nxt_div[addr_ff[3:2]] = (hwdata[15:0] < DIV_MIN) ? DIV_MIN : hwdata[15:0];
               end
            end
         endcase
      end
      // Pulse generation per output
      for (int i = 0; i < NOUT; i++) begin
         inc = dfc_pulse[i] && !clr_ff;
         lim = mode_ff[MODE_WM+i] ? 21'(wtmr_ff * TMR_MULT) : 21'(FIX_W_CYC);
         hlim = 16'((17'(div_ff[i]) + 17'h00001) >> 1);
         hold = mode_ff[MODE_WM+i] && no_load;
         net_n = net_ff[i] + (dfc_neg[i] ? -17'sh00001 : 17'sh00001);
         emit = inc && (17'(cnt_ff[i]) + 17'h00001 >= 17'(div_ff[i]));
         if (st_ff[i] == PS_LOW) begin
            if (wcnt_ff[i] < lim) begin
               nxt_wcnt[i] = wcnt_ff[i] + 21'h000001;
            end
            if (inc && half_ff[i] < hlim) begin
               nxt_half[i] = half_ff[i] + 16'h0001;
            end
            wend = (nxt_wcnt[i] >= lim) || (nxt_half[i] >= hlim);
            if (wend && !hold) begin
               nxt_st[i] = PS_IDLE;
            end
         end
         if (clr_ff) begin
            nxt_cnt[i] = '0;
            nxt_net[i] = '0;
         end else if (emit) begin
            nxt_cnt[i] = '0;
            nxt_net[i] = '0;
            nxt_sgn[i] = net_n < 0;
            nxt_seen[i] = 1'b1;
            if (seen_ff[i] && (sgn_ff[i] != (net_n < 0))) begin
               setv[ST_REV+i] = 1'b1;
            end
            if (!mode_ff[i]) begin
               setv[ST_RDY+i] = 1'b1;
               nxt_st[i] = PS_LOW;
               nxt_wcnt[i] = '0;
               nxt_half[i] = '0;
            end
         end else if (inc) begin
            nxt_cnt[i] = cnt_ff[i] + 16'h0001;
            nxt_net[i] = net_n;
         end
         if (mode_ff[i]) begin
            nxt_st[i] = PS_IDLE;
         end
      end
      // Power events
      setv[ST_RAP +: 3] = rap;
      setv[ST_RRP +: 3] = rrp;
      setv[ST_PRDY] = pw_rdy;
      // Write-one-to-clear, a new event wins
      nxt_stat = stat_ff;
      nxt_evt = evt_ff;
      if (wr_ff && addr_ff == A_STAT) begin
         nxt_stat = stat_ff & ~hwdata[ST_W-1:0];
      end
      if (wr_ff && addr_ff == A_EVT) begin
         nxt_evt = evt_ff & ~hwdata[ST_W-1:0];
      end
      nxt_stat = nxt_stat | setv;
      nxt_evt = nxt_evt | (setv & ~{1'b0, 6'h00, 4'h0, {NOUT{1'b1}}});
      // Read data captured in the address phase
      if (take && !hwrite) begin
         case (ra)
            A_MODE:  nxt_rd = {23'h000000, mode_ff};
            A_WTMR:  nxt_rd = {13'h0000, wtmr_ff};
            A_CFG:   nxt_rd = 32'h00000000;
            A_PTIME: nxt_rd = {19'h00000, ptime_ff};
            A_STAT:  nxt_rd = {17'h00000, stat_ff};
            A_EVT:   nxt_rd = {17'h00000, evt_ff};
            A_MASK:  nxt_rd = {17'h00000, mask_ff};
            A_SIGN:  nxt_rd = {22'h000000, rsgn_ff, asgn_ff, sgn_ff};
            default: begin
               nxt_rd = 32'h00000000;
               if (ra >= A_DIV && ra < A_STAT) begin
                  nxt_rd = {16'h0000, div_ff[ra[3:2]]};
               end else if (ra >= A_PWR && ra < A_PN) begin
                  idx = 4'((ra - A_PWR) >> 2);
                  nxt_rd = usr_ff[idx];
               end else if (ra >= A_PN && ra < A_END) begin
                  nxt_rd = pnu_ff[2'((ra - A_PN) >> 2)];
               end
            end
         endcase
      end
   end

   // ***************************************************
   // Power accumulation
   // ***************************************************
   always_comb begin
      logic               last;
      logic signed [44:0] s;
      logic signed [44:0] v;
      logic               nr;
      last = scnt_ff >= ptime_ff;
      s = '0;
      v = '0;
      nr = 1'b0;
      pw_rdy = 1'b0;
      rap = '0;
      rrp = '0;
      nxt_acc = acc_ff;
      nxt_usr = usr_ff;
      nxt_pn = pn_ff;
      nxt_pnu = pnu_ff;
      nxt_scnt = scnt_ff;
      nxt_asgn = asgn_ff;
      nxt_rsgn = rsgn_ff;
      if (smp_stb) begin
         nxt_scnt = last ? 13'h0000 : scnt_ff + 13'h0001;
         for (int t = 0; t < 3; t++) begin
            for (int p = 0; p < NPH; p++) begin
               s = acc_ff[t*NPH+p] + sx(pick(smp[p], t));
               nxt_acc[t*NPH+p] = last ? 45'sh0 : s;
               if (last) begin
                  nxt_usr[t*NPH+p] = s[44:13];
               end
            end
         end
         for (int k = 0; k < 2; k++) begin
            for (int p = 0; p < NPH; p++) begin
               v = sx(pick(smp[p], k));
               if (v < 0) begin
                  nxt_pn[2*k+1] = nxt_pn[2*k+1] - v;
               end else begin
                  nxt_pn[2*k] = nxt_pn[2*k] + v;
               end
            end
         end
         if (last) begin
            pw_rdy = 1'b1;
            for (int j = 0; j < 4; j++) begin
               nxt_pnu[j] = nxt_pn[j][44:13];
               nxt_pn[j] = '0;
            end
            for (int p = 0; p < NPH; p++) begin
               nr = mode_ff[MODE_SS] ? nxt_usr[2*NPH+p][31] : nxt_usr[NPH+p][31];
               nxt_asgn[p] = nxt_usr[p][31];
               nxt_rsgn[p] = nr;
               rap[p] = nxt_usr[p][31] != asgn_ff[p];
               rrp[p] = nr != rsgn_ff[p];
            end
         end
      end
   end

   // ***************************************************
   // Flip-flops
   // ***************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_ff <= 9'h000;
         wtmr_ff <= WTMR_RST;
         ptime_ff <= PTIME_RST;
         stat_ff <= '0;
         evt_ff <= '0;
         mask_ff <= '0;
         clr_ff <= 1'b0;
         addr_ff <= 8'h00;
         wr_ff <= 1'b0;
         rd_ff <= 32'h00000000;
         sgn_ff <= '0;
         seen_ff <= '0;
         scnt_ff <= 13'h0000;
         asgn_ff <= 3'h0;
         rsgn_ff <= 3'h0;
         for (int i = 0; i < NOUT; i++) begin
            div_ff[i] <= DIV_RST;
            st_ff[i] <= PS_IDLE;
            cnt_ff[i] <= 16'h0000;
            half_ff[i] <= 16'h0000;
            net_ff[i] <= 17'sh00000;
            wcnt_ff[i] <= 21'h000000;
         end
         for (int j = 0; j < NPWR; j++) begin
            acc_ff[j] <= 45'sh0;
            usr_ff[j] <= 32'h00000000;
         end
         for (int j = 0; j < 4; j++) begin
            pn_ff[j] <= 45'sh0;
            pnu_ff[j] <= 32'h00000000;
         end
      end else begin
         mode_ff <= nxt_mode;
         wtmr_ff <= nxt_wtmr;
         ptime_ff <= nxt_ptime;
         div_ff <= nxt_div;
         stat_ff <= nxt_stat;
         evt_ff <= nxt_evt;
         mask_ff <= nxt_mask;
         clr_ff <= nxt_clr;
         addr_ff <= nxt_addr;
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         half_ff <= nxt_half;
         net_ff <= nxt_net;
         wcnt_ff <= nxt_wcnt;
         sgn_ff <= nxt_sgn;
         seen_ff <= nxt_seen;
         acc_ff <= nxt_acc;
         usr_ff <= nxt_usr;
         pn_ff <= nxt_pn;
         pnu_ff <= nxt_pnu;
         scnt_ff <= nxt_scnt;
         asgn_ff <= nxt_asgn;
         rsgn_ff <= nxt_rsgn;
      end
   end

endmodule

// File: verification/pa_top_sva.sv
`timescale 1ns/1ns
module pa_top_sva
   import pa_pkg::*;
#(
   parameter int unsigned FIX_W_CYC = FIX_CYC
)(
   // Clock and reset
   input wire logic            hclk,
   input wire logic            hresetn,
   // Bus side
   input wire logic            hsel,
   input wire logic [31:0]     haddr,
   input wire logic [1:0]      htrans,
   input wire logic            hwrite,
   input wire logic [31:0]     hwdata,
   input wire logic            hready,
   input wire logic            hreadyout,
   input wire logic            hresp,
   input wire logic [31:0]     hrdata,
   // Pulse and power side
   input wire logic            smp_stb,
   input wire logic [NOUT-1:0] dfc_pulse,
   input wire logic            no_load,
   input wire logic            dfc_clr,
   input wire logic [NOUT-1:0] cf_n,
   input wire logic            int_line_zero_n
);
   // ****
   // Shadow of mode and width timer, low-time counter
   // ****
   logic        wr_ff, nxt_wr, nl_ff, nxt_nl;
   logic [7:0]  wa_ff, nxt_wa;
   logic [31:0] mode_ff, nxt_mode, wtmr_ff, nxt_wtmr, low_ff, nxt_low;
   // ****
   // Next values
   always_comb begin
      nxt_wr = hsel && hready && htrans[1] && hwrite;
      nxt_wa = haddr[7:0];
      nxt_mode = (wr_ff && wa_ff == A_MODE) ? hwdata : mode_ff;
      nxt_wtmr = (wr_ff && wa_ff == A_WTMR) ? hwdata : wtmr_ff;
      nxt_low = cf_n[0] ? 32'h0 : low_ff + 32'h1;
      nxt_nl = !cf_n[0] && (nl_ff || no_load);
   end
   // Registers only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ff <= 1'b0;
         nl_ff <= 1'b0;
         wa_ff <= 8'h0;
         mode_ff <= 32'h0;
         wtmr_ff <= {13'h0, WTMR_RST};
         low_ff <= 32'h0;
      end else begin
         wr_ff <= nxt_wr;
         nl_ff <= nxt_nl;
         wa_ff <= nxt_wa;
         mode_ff <= nxt_mode;
         wtmr_ff <= nxt_wtmr;
         low_ff <= nxt_low;
      end
   end
   // Clear command: address phase then data with bit 0 set
   sequence s_clr_wr;
      hsel && hready && htrans[1] && hwrite && haddr[7:0] == A_CFG ##1 hwdata[0];
   endsequence
   a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn) hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_clr_follows: assert property (@(posedge hclk) disable iff (!hresetn) s_clr_wr |-> ##[1:2] dfc_clr)
      else $error("no clear pulse after clear write");
   a_clr_single: assert property (@(posedge hclk) disable iff (!hresetn) dfc_clr |=> !dfc_clr)
      else $error("clear pulse longer than one cycle");
   a_cf_cause: assert property (@(posedge hclk) disable iff (!hresetn)
      (|(~cf_n & $past(cf_n))) |-> |$past(dfc_pulse))
      else $error("pulse pin fell without converter pulse");
   a_dis_high: assert property (@(posedge hclk) disable iff (!hresetn)
      ((mode_ff[3:0] & $past(mode_ff[3:0])) & ~cf_n) == 4'h0)
      else $error("disabled pulse pin went low");
   a_width_bound: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(cf_n[0]) && !nl_ff |-> low_ff <= (mode_ff[4] ? wtmr_ff * 32'd6 : FIX_W_CYC))
      else $error("pulse low time too long");
   a_rd_stable: assert property (@(posedge hclk) disable iff (!hresetn)
      !$stable(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
      else $error("read data changed without read");
   a_int_cause: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(int_line_zero_n) |-> $past(wr_ff || smp_stb || (|dfc_pulse)) || $past(smp_stb, 2))
      else $error("interrupt without cause");
endmodule
bind pa_top pa_top_sva #(.FIX_W_CYC(FIX_W_CYC)) pa_top_sva_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .smp_stb(smp_stb), .dfc_pulse(dfc_pulse),
   .no_load(no_load), .dfc_clr(dfc_clr), .cf_n(cf_n), .int_line_zero_n(int_line_zero_n));

// File: verification/pa_pulse_mon.sv
`timescale 1ns/1ns
module pa_pulse_mon
   import pa_pkg::*;
(
   // Clock
   input wire logic            hclk,
   // Pulse pins
   input wire logic [NOUT-1:0] cf_n,
   // Pulses counted, last low width
   output int                  cnt [NOUT],
   output int                  wid [NOUT]
);
   int run [NOUT];
   // ****
   // Count pulses, time each low phase
   // ****
   initial begin
      cnt = '{default: 0};
      wid = '{default: 0};
      run = '{default: 0};
   end
   always @(posedge hclk) begin
      for (int i = 0; i < NOUT; i++) begin
         if (!cf_n[i]) begin
            cnt[i] <= (run[i] == 0) ? cnt[i] + 1 : cnt[i];
            run[i] <= run[i] + 1;
         end else if (run[i] != 0) begin
            wid[i] <= run[i];
            run[i] <= 0;
         end
      end
   end
endmodule

// File: verification/tb_pa_top.sv
`timescale 1ns/1ns
module tb_pa_top
   import pa_pkg::*;
;
   localparam int unsigned FW = 20;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        smp_stb = 1'b0;
   logic        no_load = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0]  dfc_pulse = 4'h0;
   logic [3:0]  dfc_neg = 4'h0;
   pa_pwr_t     smp [NPH] = '{default: '0};
   logic        hreadyout, hresp, dfc_clr, int_line_zero_n;
   logic [31:0] hrdata;
   logic [3:0]  cf_n;
   int          cnt [NOUT];
   int          wid [NOUT];
   int          error_cnt = 0;
   int          checks_done = 0;
   int          cyc = 0;
   // ****
   // Design, pulse counter, clock, timeout
   // ****
   pa_top #(.FIX_W_CYC(FW)) pa_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .smp_stb(smp_stb), .smp(smp),
      .dfc_pulse(dfc_pulse), .dfc_neg(dfc_neg), .no_load(no_load), .dfc_clr(dfc_clr), .cf_n(cf_n),
      .int_line_zero_n(int_line_zero_n));
   pa_pulse_mon pa_pulse_mon_inst (.hclk(hclk), .cf_n(cf_n), .cnt(cnt), .wid(wid));
   initial forever #25 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic test_done();
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // Single bus transfer, waits on ready in both phases
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   task automatic clr();
      wr(A_CFG, 32'h1);
      repeat (3) @(posedge hclk);
   endtask
   // One internal pulse on output 0
   task automatic dp(input logic neg, input int gap);
      dfc_pulse <= 4'h1;
      dfc_neg <= {3'h0, neg};
      @(posedge hclk);
      dfc_pulse <= 4'h0;
      repeat (gap) @(posedge hclk);
   endtask
   task automatic nl_pulse();
      dp(1'b0, 1);
      dp(1'b0, 1);
      no_load <= 1'b1;
      repeat (40) @(posedge hclk);
      no_load <= 1'b0;
      repeat (5) @(posedge hclk);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_regs();
      rc(A_MODE, 32'h0);
      chk({28'h0, cf_n}, 32'hF);
      chk({31'h0, int_line_zero_n}, 32'h1);
      rc(A_WTMR, 32'h50000);
      rc(A_PTIME, 32'hF9F);
      rc(A_DIV + 8'hC, 32'hFFFF);
      rc(8'hF0, 32'h0);
      wr(A_DIV, 32'h1);
      rc(A_DIV, 32'h2);
      wr(A_PTIME, 32'hFFFF);
      rc(A_PTIME, 32'h1FFF);
      $display("t_regs done");
   endtask
   task automatic t_width();
      int d;
      wr(A_DIV, 32'h2);
      clr();
      repeat (2) dp(1'b0, 30);
      chk(32'(wid[0]), FW);
      rc(A_STAT, 32'h1);
      for (d = 2; d < 4; d++) begin
         wr(A_DIV, 32'(d));
         clr();
         repeat (2 * d - 1) dp(1'b0, 3);
         repeat (3) @(posedge hclk);
         chk(32'(wid[0]), 32'(d % 2 ? 2 * d + 2 : 2 * d));
      end
      $display("t_width done");
   endtask
   task automatic t_mode1();
      wr(A_MODE, 32'h10);
      wr(A_WTMR, 32'h3);
      wr(A_DIV, 32'h2);
      clr();
      repeat (2) dp(1'b0, 30);
      chk(32'(wid[0]), 32'h12);
      nl_pulse();
      chk(32'(wid[0] > 40), 32'h1);
      wr(A_MODE, 32'h0);
      nl_pulse();
      chk(32'(wid[0]), FW);
      $display("t_mode1 done");
   endtask
   task automatic t_sign();
      int n;
      wr(A_MASK, 32'h10);
      wr(A_STAT, 32'h7FFF);
      wr(A_EVT, 32'h7FFF);
      clr();
      repeat (2) dp(1'b1, 30);
      rc(A_SIGN, 32'h1);
      rc(A_EVT, 32'h10);
      chk({31'h0, int_line_zero_n}, 32'h0);
      wr(A_STAT, 32'h11);
      wr(A_EVT, 32'h10);
      @(posedge hclk);
      chk({31'h0, int_line_zero_n}, 32'h1);
      wr(A_MODE, 32'h1);
      n = cnt[0];
      repeat (2) dp(1'b0, 30);
      chk(32'(cnt[0] - n), 32'h0);
      rc(A_STAT, 32'h10);
      rc(A_SIGN, 32'h0);
      wr(A_MODE, 32'h0);
      wr(A_MASK, 32'h0);
      $display("t_sign done");
   endtask
   task automatic t_clear();
      int n;
      clr();
      n = cnt[0];
      dp(1'b0, 30);
      clr();
      rc(A_CFG, 32'h0);
      dp(1'b0, 30);
      chk(32'(cnt[0] - n), 32'h0);
      dp(1'b0, 30);
      chk(32'(cnt[0] - n), 32'h1);
      $display("t_clear done");
   endtask
   task automatic t_power();
      int m;
      wr(A_STAT, 32'h7FFF);
      wr(A_PTIME, 32'h1);
      smp[0] <= '{32'h3000, 32'h4000, 32'hFFFFC000};
      smp[1] <= '{32'hFFFFE000, 32'h0, 32'h0};
      smp[2] <= '{32'hFFFFFFFF, 32'h0, 32'h0};
      for (m = 0; m < 2; m++) begin
         wr(A_MODE, m ? 32'h100 : 32'h0);
         repeat (2) begin
            smp_stb <= 1'b1;
            @(posedge hclk);
            smp_stb <= 1'b0;
            repeat (3) @(posedge hclk);
         end
         rc(A_PWR, 32'h3);
         rc(A_PWR + 8'h4, 32'hFFFFFFFE);
         rc(A_PWR + 8'h8, 32'hFFFFFFFF);
         rc(A_PWR + 8'hC, 32'h4);
         rc(A_PWR + 8'h18, 32'hFFFFFFFC);
         rc(A_PN, 32'h3);
         rc(A_PN + 8'h4, 32'h2);
         rc(A_PN + 8'h8, 32'h4);
         rc(A_PN + 8'hC, 32'h0);
         rc(A_SIGN, m ? 32'hE0 : 32'h60);
         rc(A_STAT, m ? 32'h4800 : 32'h4600);
         wr(A_STAT, 32'h7FFF);
      end
      $display("t_power done");
   endtask
   // Reset, then run every scenario
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_width();
      t_mode1();
      t_sign();
      t_clear();
      t_power();
      test_done();
   end
endmodule
